// >>> logic/vdsp_pkg.sv
// Functional notes
// R1 - Host uses naturally aligned word and double accesses
// R2 - Read-only registers ignore writes; abort is write-only
// R3 - Accumulator bits 30:15 map to operand halves
// R4 - Host accumulator store copies rounding bit to 14
// R5 - Accumulator loads sign-extend bit 30 into 33:31
// R6 - Host or plain load clears bits 13:0
// R7 - Pointer holds address, wrap and increment fields
// R8 - Working incrementor steps and wraps per pointer
// R9 - Software keeps wrap exponent not below increment
// R10 - External address is base plus twice word address
// R11 - Base low bits zero; never use reserved base
// R12 - Command pointer write starts list; idle access only
// R13 - Each fetch advances command pointer to next
// R14 - Overflow when ALU bits 32 and 33 differ
// R15 - Out-of-range accumulator read clips and flags
// R16 - Overflow register clears on reset, abort, read
// R17 - Options register field layout
// R18 - Length nonzero; changed only by options load
// R19 - Loop count changes only on decrement-branch
// R20 - Abort halts and clears overflow, hold, halt bits; an abort while running sets the halt request instead of clearing it
// R21 - Stall external references while hold bit set
// R22 - Run status bit zero idle, one active
// R23 - Halt request set on stop; masked interrupt
// R24 - Host access while running flags fault source
// R25 - Run drops when halt request becomes set
package vdsp_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_OPTIONS  = 32'hffff8000;
  localparam logic [31:0] ADDR_OVF      = 32'hffff8004;
  localparam logic [31:0] ADDR_PTR1     = 32'hffff8008;
  localparam logic [31:0] ADDR_PTR2     = 32'hffff800c;
  localparam logic [31:0] ADDR_PTR3     = 32'hffff8010;
  localparam logic [31:0] ADDR_ACC      = 32'hffff8014;
  localparam logic [31:0] ADDR_LOOP     = 32'hffff8018;
  localparam logic [31:0] ADDR_CMDPTR   = 32'hffff8020;
  localparam logic [31:0] ADDR_BASE     = 32'hffff8024;
  localparam logic [31:0] ADDR_RUN      = 32'hffff9000;
  localparam logic [31:0] ADDR_ABORT    = 32'hffff9004;
  localparam logic [31:0] ADDR_HALTREQ  = 32'hffff9008;
  localparam logic [31:0] ADDR_HALTEN   = 32'hffff900c;
  localparam logic [31:0] ADDR_HOLD     = 32'hffff9010;
  localparam logic [31:0] ADDR_FAULT    = 32'hffff9014;
  // Engine address space window (upper half of address)
  localparam logic [15:0] ENGINE_HI     = 16'hffff;
  // Field positions
  localparam int OVF_BIT     = 0;
  localparam int CLIP_BIT    = 1;
  localparam int FAULT_ERR   = 2;
  localparam int OPT_RND     = 25;
  localparam int ACC_RND_POS = 14;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  // Clip limits of a 16-bit result
  localparam logic [15:0] CLIP_MAX = 16'h7fff;
  localparam logic [15:0] CLIP_MIN = 16'h8000;
endpackage : vdsp_pkg

// >>> logic/vdsp_regs.sv
`timescale 1ns/1ps
module vdsp_regs #(
  parameter int ADDR_W = 16                // Word address width of a vector pointer
) (
  input  wire logic        mclk,           // Processor clock, 25 MHz
  input  wire logic        rst_n,          // Synchronous reset, active low
  // Host side of the internal bus
  input  wire logic [31:0] hostAddr,       // Byte address
  input  wire logic        hostWrEn,       // Write strobe, one cycle
  input  wire logic        hostRdEn,       // Read strobe, one cycle
  input  wire logic [31:0] hostWrData,     // Write data
  output logic      [31:0] hostRdData,     // Read data, valid with hostRdValid
  output logic             hostRdValid,    // One cycle after hostRdEn
  // Command-list execution unit side
  input  wire logic        exuFetch,       // Command fetched from engine RAM
  input  wire logic        exuListEnd,     // List finished, stop
  input  wire logic        exuVecStart,    // Vector operation starts
  input  wire logic [2:0]  exuStep,        // Step incrementor per pointer
  input  wire logic [1:0]  exuExtSel,      // Pointer for external address
  input  wire logic        exuExtReq,      // External reference wanted
  input  wire logic        exuAluValid,    // ALU result valid
  input  wire logic        exuAluInt,      // Integer data: no overflow check
  input  wire logic [33:0] exuAluResult,   // 34-bit ALU result
  input  wire logic        exuLoadAccPlain,// Plain accumulator load
  input  wire logic        exuLoadAccExt,  // Extended accumulator load
  input  wire logic [30:0] exuAccRe,       // Load data, real part
  input  wire logic [30:0] exuAccIm,       // Load data, imaginary part
  input  wire logic        exuFlagStore,   // Flag store instruction reads overflow
  input  wire logic        exuOptionsLoad, // Options load instruction
  input  wire logic        exuBaseLoad,    // Base load instruction
  input  wire logic [31:0] exuLoadData,    // Data for options or base load
  input  wire logic        exuLoopDec,     // Decrement-and-branch executes
  output logic             runStatus,      // Command list active
  output logic [15:0]      cmdPointer,     // Current command address
  output logic [15:0]      loopTarget,     // Jump target
  output logic             loopZero,       // Loop count is zero
  output logic [31:0]      vectorOptions,  // Options register to the datapath
  output logic [67:0]      accValue,       // Imag 67:34, real 33:0
  output logic [3*ADDR_W-1:0] ptrWork,     // Working incrementors
  output logic [31:0]      extAddr,        // External byte address
  output logic             extGrant,       // External reference may proceed
  output logic             haltIrq,        // Masked halt interrupt request
  output logic             nmiReq          // Non-maskable request
);

  initial begin
    if (ADDR_W != 16) begin
      $error("vdsp_regs serves a 16-bit pointer address only");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Step within a cyclic buffer: only bits under the wrap mask move
  function automatic logic [15:0] ptrStep(input logic [15:0] a, input logic [3:0] inc,
                                          input logic [3:0] wrp);
    logic [15:0] mask;
    logic [15:0] sum;
    mask = 16'(17'h1_0000 >> (5'h10 - {1'b0, wrp})) - 16'h0001;
    if (wrp == 4'h0) begin
      mask = 16'h0000;
    end
    sum = a + (16'h0001 << inc);
    ptrStep = (a & ~mask) | (sum & mask);
  endfunction : ptrStep

  // Clip one part to a 16-bit view of bits 30:15
  function automatic logic [16:0] accClip(input logic [33:0] p);
    if (p[33:30] == 4'h0 || p[33:30] == 4'hf) begin
      accClip = {1'b0, p[30:15]};
    end else if (p[33]) begin
      accClip = {1'b1, vdsp_pkg::CLIP_MIN};
    end else begin
      accClip = {1'b1, vdsp_pkg::CLIP_MAX};
    end
  endfunction : accClip

  // Sign extend bit 30 and optionally clear low bits
  function automatic logic [33:0] accLoad(input logic [30:0] v, input logic clrLow);
    accLoad = {{3{v[30]}}, v};                          // see R5
    if (clrLow) begin
      accLoad[13:0] = 14'h0000;                         // see R6
    end
  endfunction : accLoad

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic        inSpace;        // Access falls in engine space
  logic        exempt;         // Interface register, allowed while running
  logic        wrAbort;        // Abort write
  logic        hRd;            // Host read of any register
  logic        hWr;            // Host write of any register
  logic [16:0] clipRe;         // Clipped real view
  logic [16:0] clipIm;         // Clipped imaginary view

  assign hRd = hostRdEn;
  assign hWr = hostWrEn;
  assign inSpace = hostAddr[31:16] == vdsp_pkg::ENGINE_HI;
  assign exempt = hostAddr == vdsp_pkg::ADDR_RUN || hostAddr == vdsp_pkg::ADDR_HOLD ||
                  hostAddr == vdsp_pkg::ADDR_HALTREQ || hostAddr == vdsp_pkg::ADDR_FAULT ||
                  hostAddr == vdsp_pkg::ADDR_HALTEN || hostAddr == vdsp_pkg::ADDR_ABORT;
  assign wrAbort = hWr && hostAddr == vdsp_pkg::ADDR_ABORT;

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [31:0] options_q;      // Options register
  logic [1:0]  ovf_q;          // Overflow and clip flags
  logic [31:0] ptr_q [3];      // Vector pointers
  logic [15:0] work_q [3];     // Working incrementors
  logic [33:0] accRe_q;        // Accumulator real part
  logic [33:0] accIm_q;        // Accumulator imaginary part
  logic [31:0] loop_q;         // Count 15:0, target 31:16
  logic [15:0] cmdPtr_q;       // Command pointer
  logic [31:0] base_q;         // External base
  logic        run_q;          // Run status
  logic        haltReq_q;      // Halt request
  logic        haltEn_q;       // Halt enable
  logic        hold_q;         // Hold control
  logic [2:0]  fault_q;        // Fault source
  logic        stop;           // Execution stops this cycle

  assign clipRe = accClip(accRe_q);
  assign clipIm = accClip(accIm_q);
  assign stop = run_q && (exuListEnd || wrAbort);

  ////////////////////////////////////////////////////////////////////////////
  // Options register, host or options load only

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      options_q <= vdsp_pkg::RST_WORD;
    end else if (hWr && hostAddr == vdsp_pkg::ADDR_OPTIONS) begin
      options_q <= hostWrData;                          // see R17
    end else if (exuOptionsLoad) begin
      options_q <= exuLoadData;                         // see R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow and clip flags; a set in the clearing cycle wins

  logic ovfSet;                // ALU overflow this cycle
  logic clipSet;               // Host accumulator read clipped
  logic ovfClr;                // Read or abort clears
  assign ovfSet = exuAluValid && !exuAluInt && (exuAluResult[33] != exuAluResult[32]); // see R14
  assign clipSet = hRd && hostAddr == vdsp_pkg::ADDR_ACC && (clipRe[16] || clipIm[16]); // see R15
  assign ovfClr = wrAbort || exuFlagStore || (hRd && hostAddr == vdsp_pkg::ADDR_OVF);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovf_q <= 2'h0;
    end else begin
      ovf_q[vdsp_pkg::OVF_BIT]  <= ovfSet  || (ovf_q[vdsp_pkg::OVF_BIT]  && !ovfClr);  // see R16
      ovf_q[vdsp_pkg::CLIP_BIT] <= clipSet || (ovf_q[vdsp_pkg::CLIP_BIT] && !ovfClr);  // see R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector pointers and their working incrementors

  for (genvar i = 0; i < 3; i++) begin : g_ptr
    localparam logic [31:0] PADDR = vdsp_pkg::ADDR_PTR1 + 32'(4 * i);
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        ptr_q[i] <= vdsp_pkg::RST_WORD;
      end else if (hWr && hostAddr == PADDR) begin
        ptr_q[i] <= {hostWrData[31:16], 8'h00, hostWrData[7:0]};   // see R7
      end
    end
    // Copy at vector start, then step and wrap
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        work_q[i] <= vdsp_pkg::RST_HALF;
      end else if (exuVecStart) begin
        work_q[i] <= ptr_q[i][31:16];                   // see R8
      end else if (exuStep[i]) begin
        work_q[i] <= ptrStep(work_q[i], ptr_q[i][3:0], ptr_q[i][7:4]); // see R8
      end
    end
    assign ptrWork[i*ADDR_W +: ADDR_W] = work_q[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Complex accumulator

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      accRe_q <= 34'h0;
      accIm_q <= 34'h0;
    end else if (hWr && hostAddr == vdsp_pkg::ADDR_ACC) begin
      // Rounding bit lands just under the visible field
      accRe_q <= accLoad({hostWrData[15:0], 15'h0000}, 1'b1);  // see R3
      accIm_q <= accLoad({hostWrData[31:16], 15'h0000}, 1'b1); // see R3
      accRe_q[vdsp_pkg::ACC_RND_POS] <= options_q[vdsp_pkg::OPT_RND]; // see R4
      accIm_q[vdsp_pkg::ACC_RND_POS] <= options_q[vdsp_pkg::OPT_RND]; // see R4
    end else if (exuLoadAccPlain || exuLoadAccExt) begin
      accRe_q <= accLoad(exuAccRe, exuLoadAccPlain);    // see R5
      accIm_q <= accLoad(exuAccIm, exuLoadAccPlain);    // see R6
    end
  end
  assign accValue = {accIm_q, accRe_q};

  ////////////////////////////////////////////////////////////////////////////
  // Loop register: count moves only on decrement-and-branch

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loop_q <= vdsp_pkg::RST_WORD;
    end else if (hWr && hostAddr == vdsp_pkg::ADDR_LOOP) begin
      loop_q <= hostWrData;
    end else if (exuLoopDec && loop_q[15:0] != 16'h0000) begin
      loop_q[15:0] <= loop_q[15:0] - 16'h0001;          // see R19
    end
  end
  assign loopTarget = loop_q[31:16];
  assign loopZero = loop_q[15:0] == 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Command pointer and run state

  logic startList;             // Host write of the command pointer while idle
  assign startList = hWr && hostAddr == vdsp_pkg::ADDR_CMDPTR && !run_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmdPtr_q <= vdsp_pkg::RST_HALF;
    end else if (startList) begin
      cmdPtr_q <= hostWrData[15:0];                     // see R12
    end else if (run_q && exuFetch) begin
      cmdPtr_q <= cmdPtr_q + 16'h0001;                  // see R13
    end
  end

  // Stop beats start; idle writes while running are refused
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_q <= 1'b0;
    end else if (stop) begin
      run_q <= 1'b0;                                    // see R25
    end else if (startList) begin
      run_q <= 1'b1;                                    // see R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External base and address

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      base_q <= vdsp_pkg::RST_WORD;
    end else if (hWr && hostAddr == vdsp_pkg::ADDR_BASE) begin
      base_q <= hostWrData;                             // Software keeps 16:0 zero
    end else if (exuBaseLoad) begin
      base_q <= exuLoadData;
    end
  end

  // Registered so the address is a flop output
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      extAddr <= vdsp_pkg::RST_WORD;
    end else begin
      extAddr <= base_q + {15'h0000, work_q[exuExtSel == 2'h3 ? 2'h0 : exuExtSel], 1'b0}; // see R10
    end
  end
  assign extGrant = exuExtReq && !hold_q;               // see R21

  ////////////////////////////////////////////////////////////////////////////
  // Interface registers: hold, halt request, halt enable, fault

  always_ff @(posedge mclk) begin
    if (!rst_n || wrAbort) begin
      hold_q <= 1'b0;                                   // see R20
    end else if (hWr && hostAddr == vdsp_pkg::ADDR_HOLD) begin
      hold_q <= hostWrData[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || wrAbort) begin
      haltEn_q <= 1'b0;                                 // see R20
    end else if (hWr && hostAddr == vdsp_pkg::ADDR_HALTEN) begin
      haltEn_q <= hostWrData[0];
    end
  end

  // Halt stays set when stop and read coincide
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      haltReq_q <= 1'b0;
    end else if (stop) begin
      haltReq_q <= 1'b1;                                // see R23
    end else if (wrAbort || (hRd && hostAddr == vdsp_pkg::ADDR_HALTREQ)) begin
      haltReq_q <= 1'b0;                                // see R23
    end
  end
  assign haltIrq = haltReq_q && haltEn_q;               // see R23

  logic faultSet;              // Forbidden access while running
  assign faultSet = run_q && (hRd || hWr) && inSpace && !exempt;   // see R24
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_q <= 3'h0;
    end else if (faultSet) begin
      fault_q[vdsp_pkg::FAULT_ERR] <= 1'b1;             // see R24
    end else if (hRd && hostAddr == vdsp_pkg::ADDR_FAULT) begin
      fault_q <= 3'h0;
    end
  end
  assign nmiReq = |fault_q;

  assign runStatus = run_q;
  assign cmdPointer = cmdPtr_q;
  assign vectorOptions = options_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; write-only and unmapped read as zero

  logic [31:0] rdMux;          // Combinational read value
  always_comb begin
    rdMux = vdsp_pkg::RST_WORD;                         // see R2
    if (hostAddr == vdsp_pkg::ADDR_OPTIONS) begin
      rdMux = options_q;
    end else if (hostAddr == vdsp_pkg::ADDR_OVF) begin
      rdMux = {30'h0, ovf_q};
    end else if (hostAddr == vdsp_pkg::ADDR_PTR1) begin
      rdMux = ptr_q[0];
    end else if (hostAddr == vdsp_pkg::ADDR_PTR2) begin
      rdMux = ptr_q[1];
    end else if (hostAddr == vdsp_pkg::ADDR_PTR3) begin
      rdMux = ptr_q[2];
    end else if (hostAddr == vdsp_pkg::ADDR_ACC) begin
      rdMux = {clipIm[15:0], clipRe[15:0]};             // see R15
    end else if (hostAddr == vdsp_pkg::ADDR_LOOP) begin
      rdMux = loop_q;
    end else if (hostAddr == vdsp_pkg::ADDR_CMDPTR) begin
      rdMux = {16'h0000, cmdPtr_q};
    end else if (hostAddr == vdsp_pkg::ADDR_BASE) begin
      rdMux = base_q;
    end else if (hostAddr == vdsp_pkg::ADDR_RUN) begin
      rdMux = {31'h0, run_q};                           // see R22
    end else if (hostAddr == vdsp_pkg::ADDR_HALTREQ) begin
      rdMux = {31'h0, haltReq_q};
    end else if (hostAddr == vdsp_pkg::ADDR_HALTEN) begin
      rdMux = {31'h0, haltEn_q};
    end else if (hostAddr == vdsp_pkg::ADDR_HOLD) begin
      rdMux = {31'h0, hold_q};
    end else if (hostAddr == vdsp_pkg::ADDR_FAULT) begin
      rdMux = {29'h0, fault_q};
    end
  end

  // Read data is a flop; one cycle latency
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hostRdData  <= vdsp_pkg::RST_WORD;
      hostRdValid <= 1'b0;
    end else begin
      hostRdData  <= hRd ? rdMux : vdsp_pkg::RST_WORD;
      hostRdValid <= hRd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_run_halt;
    @(posedge mclk) disable iff (!rst_n) $fell(run_q) |-> haltReq_q;
  endproperty
  a_run_halt: assert property (p_run_halt) else $error("run fell without halt request"); // see R25

  property p_abort_stop;
    @(posedge mclk) disable iff (!rst_n) wrAbort |=> !run_q && !hold_q && !haltEn_q;
  endproperty
  a_abort_stop: assert property (p_abort_stop) else $error("abort did not clear state"); // see R20

  property p_start;
    @(posedge mclk) disable iff (!rst_n) startList && !exuListEnd |=> run_q && cmdPtr_q == $past(hostWrData[15:0]);
  endproperty
  a_start: assert property (p_start) else $error("list did not start"); // see R12

  property p_fetch;
    @(posedge mclk) disable iff (!rst_n) run_q && exuFetch && !startList |=> cmdPtr_q == $past(cmdPtr_q) + 16'h0001;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not advance pointer"); // see R13

  property p_ovf;
    @(posedge mclk) disable iff (!rst_n)
      exuAluValid && !exuAluInt && exuAluResult[33] != exuAluResult[32] |=> ovf_q[0];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // see R14

  property p_ovf_clear;
    @(posedge mclk) disable iff (!rst_n) exuFlagStore && !ovfSet && !clipSet |=> ovf_q == 2'h0;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared by read"); // see R16

  property p_hold;
    @(posedge mclk) disable iff (!rst_n) hold_q |-> !extGrant;
  endproperty
  a_hold: assert property (p_hold) else $error("external reference granted under hold"); // see R21

  property p_irq;
    @(posedge mclk) disable iff (!rst_n) stop ##1 haltEn_q |-> haltIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("halt interrupt missing"); // see R23

  property p_fault;
    @(posedge mclk) disable iff (!rst_n) faultSet |=> fault_q[2] && nmiReq;
  endproperty
  a_fault: assert property (p_fault) else $error("running access not flagged"); // see R24

  property p_acc_ext;
    @(posedge mclk) disable iff (!rst_n)
      exuLoadAccPlain && !hWr |=> accRe_q[13:0] == 14'h0 && accRe_q[33:31] == {3{accRe_q[30]}};
  endproperty
  a_acc_ext: assert property (p_acc_ext) else $error("accumulator load format wrong"); // see R6

  c_list: cover property (@(posedge mclk) disable iff (!rst_n) startList ##[1:20] exuListEnd);
  c_abort: cover property (@(posedge mclk) disable iff (!rst_n) run_q && wrAbort);
  c_clip: cover property (@(posedge mclk) disable iff (!rst_n) clipSet);
  c_wrap: cover property (@(posedge mclk) disable iff (!rst_n) exuStep[0] && ptr_q[0][7:4] != 4'h0);

endmodule : vdsp_regs

// >>> tb/vdsp_host_model.sv
`timescale 1ns/1ps
// Host core model: word-wide aligned accesses only
module vdsp_host_model (
  input  wire logic        mclk,
  input  wire logic [31:0] hostRdData,
  input  wire logic        hostRdValid,
  output logic      [31:0] hostAddr,
  output logic             hostWrEn,
  output logic             hostRdEn,
  output logic      [31:0] hostWrData
);
  // Idle bus at time zero
  initial begin
    hostAddr   = 32'h0000_0000;
    hostWrEn   = 1'b0;
    hostRdEn   = 1'b0;
    hostWrData = 32'h0000_0000;
  end
  // Released lines show the inverse of the last value, not a stale copy
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge mclk);
    hostAddr   = a;
    hostWrData = d;
    hostWrEn   = 1'b1;
    @(negedge mclk);
    hostWrEn   = 1'b0;
    hostAddr   = ~a;
    hostWrData = ~d;
  endtask : wr
  // Data is taken while the valid pulse stands
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(negedge mclk);
    hostAddr = a;
    hostRdEn = 1'b1;
    @(negedge mclk);
    hostRdEn = 1'b0;
    hostAddr = ~a;
    d        = (hostRdValid === 1'b1) ? hostRdData : 32'hdead_0bad;
  endtask : rd
endmodule : vdsp_host_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0;  // 25 MHz clock
  logic        rst_n;        // Sync reset
  logic [31:0] hAddr, hWd, hRd, v;
  logic        hWe, hRe, hRv;
  logic [9:0]  pulse;        // Exec unit strobes
  logic [2:0]  exuStep;
  logic [1:0]  exuExtSel;
  logic        exuExtReq, exuAluInt;
  logic [33:0] exuAluResult;
  logic [31:0] exuLoadData;
  logic        runStatus, loopZero, extGrant, haltIrq, nmiReq, hVal;
  logic [15:0] cmdPointer, loopTarget;
  logic [31:0] vectorOptions, extAddr;
  logic [67:0] accValue;
  logic [47:0] ptrWork;
  int          n_errors = 0, samples_checked = 0, cyc = 0;
  always #20 mclk = ~mclk;
  vdsp_host_model u_vdsp_host_model (.mclk(mclk), .hostRdData(hRd), .hostRdValid(hRv),
    .hostAddr(hAddr), .hostWrEn(hWe), .hostRdEn(hRe), .hostWrData(hWd));
  vdsp_regs u_vdsp_regs (.mclk(mclk), .rst_n(rst_n), .hostAddr(hAddr), .hostWrEn(hWe),
    .hostRdEn(hRe), .hostWrData(hWd), .hostRdData(hRd), .hostRdValid(hRv),
    .exuFetch(pulse[0]), .exuListEnd(pulse[1]), .exuVecStart(pulse[2]), .exuStep(exuStep),
    .exuExtSel(exuExtSel), .exuExtReq(exuExtReq), .exuAluValid(pulse[3]), .exuAluInt(exuAluInt),
    .exuAluResult(exuAluResult), .exuLoadAccPlain(pulse[8]), .exuLoadAccExt(pulse[9]),
    .exuAccRe(exuLoadData[30:0]), .exuAccIm(exuLoadData[30:0]), .exuFlagStore(pulse[6]),
    .exuOptionsLoad(pulse[5]), .exuBaseLoad(pulse[7]), .exuLoadData(exuLoadData),
    .exuLoopDec(pulse[4]), .runStatus(runStatus), .cmdPointer(cmdPointer),
    .loopTarget(loopTarget), .loopZero(loopZero), .vectorOptions(vectorOptions),
    .accValue(accValue), .ptrWork(ptrWork), .extAddr(extAddr), .extGrant(extGrant),
    .haltIrq(haltIrq), .nmiReq(nmiReq));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string n, input logic [67:0] e, input logic [67:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One-cycle exec strobe, launched off the falling edge
  task automatic pul(input int i);
    @(negedge mclk) pulse[i] = 1'b1;
    @(negedge mclk) pulse[i] = 1'b0;
  endtask : pul
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // Hang guard: tests need under a hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, pulse, exuStep, exuExtSel, exuExtReq, exuAluInt, exuAluResult, exuLoadData} = '0;
    repeat (3) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_RUN, v);
    chk("run", 0, v);
    // Host store: rounding bit copied, sign extended, low bits zero
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_OPTIONS, 32'h0200_0000);
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_ACC, 32'h8001_7fff);
    chk("acc", {34'h3_c000_c000, 34'h0_3fff_c000}, accValue);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_ACC, v);
    chk("accRd", 32'h8001_7fff, v);
    // Read-only places ignore writes; abort reads back zero
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_RUN, 32'h0000_0001);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_RUN, v);
    chk("runRo", 0, v);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_ABORT, v);
    chk("abortWo", 0, v);
    $display("test access done");
    // Pointer fields, step by 2 words, wrap in a 4-word buffer
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_PTR1, 32'h0010_ff21);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_PTR1, v);
    chk("ptr", 32'h0010_0021, v);
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_BASE, 32'h0002_0000);
    pul(2);
    chk("inc", 16'h0010, ptrWork[15:0]);
    @(negedge mclk);
    chk("ext", 32'h0002_0020, extAddr);
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk) exuStep = 3'h1;
      @(negedge mclk) exuStep = 3'h0;
      chk("step", k ? 16'h0010 : 16'h0012, ptrWork[15:0]);
    end
    // Hold stalls external references until abort clears it
    exuExtReq = 1'b1;
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_HOLD, 32'h0000_0001);
    chk("held", 0, extGrant);
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_ABORT, 32'h0000_0000);
    chk("grant", 1, extGrant);
    $display("test pointer done");
    // Overflow sets on bit 32 differing from 33, clears on read
    exuAluResult = 34'h1_0000_0000;
    pul(3);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_OVF, v);
    chk("ovf", 1, v);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_OVF, v);
    chk("ovfClr", 0, v);
    exuAluInt = 1'b1;
    pul(3);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_OVF, v);
    chk("ovfInt", 0, v);
    $display("test overflow done");
    // Start, fetch, stop, fault on access while running
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_HALTEN, 32'h0000_0001);
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_CMDPTR, 32'h0000_0040);
    chk("start", {1'b1, 16'h0040}, {runStatus, cmdPointer});
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_OPTIONS, v);
    chk("nmi", 1, nmiReq);
    pul(0);
    chk("fetch", 16'h0041, cmdPointer);
    pul(1);
    chk("stop", 2'b01, {runStatus, haltIrq});
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_HALTREQ, v);
    chk("req", 1, v);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_HALTREQ, v);
    chk("reqClr", 0, v);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_FAULT, v);
    chk("fault", 32'h0000_0004, v);
    // Abort mid-run halts and clears the enable
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_CMDPTR, 32'h0000_0010);
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_ABORT, 32'h0000_0000);
    chk("abort", 2'b00, {runStatus, haltIrq});
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_HALTEN, v);
    chk("enClr", 0, v);
    $display("test run done");
    // Loop count steps only on decrement-branch; options load
    u_vdsp_host_model.wr(vdsp_pkg::ADDR_LOOP, 32'h0005_0002);
    pul(4);
    u_vdsp_host_model.rd(vdsp_pkg::ADDR_LOOP, v);
    chk("loop", {16'h0005, 32'h0005_0001}, {loopTarget, v});
    exuLoadData = 32'h0000_0007;
    pul(5);
    chk("opts", 32'h0000_0007, vectorOptions);
    // Exec unit accumulator loads: plain clears low bits, extended keeps them
    exuLoadData = 32'h4000_0123;
    pul(8);
    chk("la", {2{34'h3_c000_0000}}, accValue);
    pul(9);
    chk("lea", {2{34'h3_c000_0123}}, accValue);
    $display("test loop done");
    conclude();
  end
endmodule : tb_top
